// ---- atcs_pkg.sv ----
// Package with register map, field layout and timing constants of the sequencer.
package atcs_pkg;
  localparam logic [7:0] ATCS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ATCS_CFG_OFS    = 8'h04;
  localparam logic [7:0] ATCS_STAT_OFS   = 8'h08;
  localparam logic [7:0] ATCS_IRQ_ST_OFS = 8'h0C;
  localparam logic [7:0] ATCS_IRQ_EN_OFS = 8'h10;
  localparam logic [7:0] ATCS_IRQ_CL_OFS = 8'h14;
  localparam int ATCS_TM_LSB  = 0;
  localparam int ATCS_TK_LSB  = 2;
  localparam int ATCS_BST_BIT = 6;
  localparam int ATCS_SC_LSB  = 3;
  localparam int ATCS_START_BIT = 0;
  localparam logic [31:0] ATCS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ATCS_CFG_RST  = 32'h0000_00F8;
  localparam int ATCS_TRACK_EXTRA = 2;
  localparam int ATCS_CONV_SAR    = 13;
  localparam int ATCS_CONV_EXTRA  = 2;
  localparam logic [1:0] ATCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ATCS_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ATCS_MODE_PRE   = 2'b00,
    ATCS_MODE_POST  = 2'b01,
    ATCS_MODE_RSVD  = 2'b10,
    ATCS_MODE_DUAL  = 2'b11
  } atcs_mode_e;
  typedef enum logic [1:0] {
    ATCS_ST_IDLE  = 2'b00,
    ATCS_ST_TRACK = 2'b01,
    ATCS_ST_CONV  = 2'b10
  } atcs_state_e;
endpackage

// ---- atcs_clk_if.sv ----
// Interface joining the sequencer to its subsystem clock tick generator.
`timescale 1ns/10ps
`default_nettype none
interface atcs_clk_if;
  logic       burst_clock_select;
  logic       burst_tick;
  logic [4:0] sar_clock_divider;
  logic       sar_run;
  logic       converter_subsystem_clock_tick;
  logic       sar_tick;
  modport gen (input burst_clock_select, burst_tick, sar_clock_divider, sar_run,
               output converter_subsystem_clock_tick, sar_tick);
  modport seq (output burst_clock_select, burst_tick, sar_clock_divider, sar_run,
               input converter_subsystem_clock_tick, sar_tick);
endinterface
`default_nettype wire

// ---- atcs_clkgen.sv ----
// Subsystem clock tick selection and SAR clock divider.
`timescale 1ns/10ps
`default_nettype none
module atcs_clkgen (
  input  wire logic clk_i,
  input  wire logic srst_i,
  atcs_clk_if.gen   cif
);
  logic [4:0] div_q;

  // The system clock ticks every cycle; the burst source arrives as a tick pulse.
  assign cif.converter_subsystem_clock_tick = cif.burst_clock_select ? cif.burst_tick : 1'b1;

  // The SAR tick fires once every divider+1 subsystem ticks while converting.
  assign cif.sar_tick = cif.sar_run && cif.converter_subsystem_clock_tick && (div_q == cif.sar_clock_divider);

  always_ff @(posedge clk_i) begin
    if (srst_i || !cif.sar_run) begin
      div_q <= 5'h00;
    end else if (cif.converter_subsystem_clock_tick) begin
      div_q <= (div_q == cif.sar_clock_divider) ? 5'h00 : div_q + 5'h01;
    end
  end
endmodule
`default_nettype wire

// ---- atcs_seq.sv ----
// Track and convert sequencer with AXI4-Lite registers and completion interrupt.
// Overview of operation
// - Mode 01b: timed tracking then conversion.
// - Post mode idles disconnected until next start.
// - Mode 11b: track, convert, then track again.
// - Conversion follows tracking with no gap.
// - Burst select picks subsystem clock source.
// - SAR clock divides subsystem clock by field plus one.
// - Always exactly one of idle, track, convert.
// - Pre mode converts immediately on start.
// - Tracking lasts field value plus two ticks.
// - Conversion lasts 13 SAR plus 2 ticks.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module atcs_seq (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        convert_start_i,
  input  wire logic        burst_tick_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic        sample_connect_o,
  output var  logic        converting_o,
  output var  logic        sar_clk_tick_o,
  output var  logic        irq_o
);
  import atcs_pkg::*;

  atcs_clk_if cif ();

  atcs_state_e state_q;
  atcs_mode_e  mode;
  logic [31:0] cfg_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_en_q;
  logic [8:0]  cnt_q;
  logic [3:0]  sar_cnt_q;
  logic        conv_tail_q;
  logic        done_ev;
  logic        ovr_ev;
  logic        start;
  logic        sw_start;
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_do;
  logic [1:0]  wr_clr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign mode = atcs_mode_e'(cfg_q[ATCS_TM_LSB +: 2]);
  assign cif.burst_clock_select = cfg_q[ATCS_BST_BIT + 8];
  assign cif.burst_tick         = burst_tick_i;
  assign cif.sar_clock_divider  = cfg_q[ATCS_SC_LSB + 8 +: 5];
  assign cif.sar_run            = (state_q == ATCS_ST_CONV) && !conv_tail_q && cnt_q == 9'h000;

  atcs_clkgen u_clkgen (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .cif    (cif)
  );

  // Write channel: address and data taken in either order, answered once both are in.
  assign wr_do = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ATCS_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          ATCS_CTRL_OFS, ATCS_CFG_OFS, ATCS_IRQ_EN_OFS, ATCS_IRQ_CL_OFS,
          ATCS_STAT_OFS, ATCS_IRQ_ST_OFS: s_axi_bresp <= ATCS_RESP_OKAY;
          default:                        s_axi_bresp <= ATCS_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration is frozen while a sequence runs so timing cannot change mid-flight.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q    <= ATCS_CFG_RST;
      irq_en_q <= 2'b00;
    end else if (wr_do) begin
      if (awaddr_q == ATCS_CFG_OFS && !converting_o) begin
        cfg_q <= merge(cfg_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
      end
      if (awaddr_q == ATCS_IRQ_EN_OFS) begin
        irq_en_q <= wstrb_q[0] ? wdata_q[1:0] : irq_en_q;
      end
    end
  end

  assign sw_start = wr_do && awaddr_q == ATCS_CTRL_OFS && wstrb_q[0] && wdata_q[ATCS_START_BIT];
  assign start    = convert_start_i || sw_start;
  assign wr_clr   = (wr_do && awaddr_q == ATCS_IRQ_CL_OFS && wstrb_q[0]) ? wdata_q[1:0] : 2'b00;

  // Sequencer: one state at a time; a start seen while converting is dropped and flagged.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q     <= ATCS_ST_IDLE;
      cnt_q       <= 9'h000;
      sar_cnt_q   <= 4'h0;
      conv_tail_q <= 1'b0;
    end else begin
      unique case (state_q)
        ATCS_ST_IDLE, ATCS_ST_TRACK: begin
          if (start && mode == ATCS_MODE_PRE) begin
            state_q   <= ATCS_ST_CONV;
            cnt_q     <= 9'(ATCS_CONV_EXTRA / 2);
            sar_cnt_q <= 4'h0;
          end else if (start) begin
            state_q <= ATCS_ST_TRACK;
            cnt_q   <= 9'(cfg_q[ATCS_TK_LSB +: 2]) + 9'(ATCS_TRACK_EXTRA);
            sar_cnt_q <= 4'hF;
          end else if (state_q == ATCS_ST_TRACK && sar_cnt_q == 4'hF && cif.converter_subsystem_clock_tick) begin
            if (cnt_q == 9'h001) begin
              state_q   <= ATCS_ST_CONV;
              cnt_q     <= 9'(ATCS_CONV_EXTRA / 2);
              sar_cnt_q <= 4'h0;
            end else begin
              cnt_q <= cnt_q - 9'h001;
            end
          end
        end
        ATCS_ST_CONV: begin
          if (cif.converter_subsystem_clock_tick && cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
            if (conv_tail_q && cnt_q == 9'h001) begin
              conv_tail_q <= 1'b0;
              sar_cnt_q   <= 4'h0;
              // Dual mode resumes free tracking; the timed phase only follows a start.
              state_q <= (mode == ATCS_MODE_DUAL) ? ATCS_ST_TRACK : ATCS_ST_IDLE;
            end
          end else if (cif.sar_tick) begin
            if (sar_cnt_q == 4'(ATCS_CONV_SAR - 1)) begin
              conv_tail_q <= 1'b1;
              cnt_q       <= 9'(ATCS_CONV_EXTRA / 2);
            end else begin
              sar_cnt_q <= sar_cnt_q + 4'h1;
            end
          end
        end
        default: state_q <= ATCS_ST_IDLE;
      endcase
    end
  end

  assign done_ev = state_q == ATCS_ST_CONV && conv_tail_q && cif.converter_subsystem_clock_tick && cnt_q == 9'h001;
  assign ovr_ev  = start && state_q == ATCS_ST_CONV;

  // Sticky flags; a new event beats a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_st_q <= 2'b00;
    end else begin
      irq_st_q <= (irq_st_q & ~wr_clr) | {ovr_ev, done_ev};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o            <= 1'b0;
      sample_connect_o <= 1'b0;
      converting_o     <= 1'b0;
      sar_clk_tick_o   <= 1'b0;
    end else begin
      irq_o            <= |(irq_st_q & irq_en_q);
      sample_connect_o <= state_q == ATCS_ST_TRACK;
      converting_o     <= state_q != ATCS_ST_IDLE && !(state_q == ATCS_ST_TRACK
                          && sar_cnt_q != 4'hF);
      sar_clk_tick_o   <= cif.sar_tick;
    end
  end

  // Read channel: one beat answered the cycle after the address is taken.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ATCS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ATCS_RESP_OKAY;
        case (s_axi_araddr)
          ATCS_CTRL_OFS:   s_axi_rdata <= ATCS_CTRL_RST;
          ATCS_CFG_OFS:    s_axi_rdata <= cfg_q;
          ATCS_STAT_OFS:   s_axi_rdata <= {29'h0, converting_o, state_q};
          ATCS_IRQ_ST_OFS: s_axi_rdata <= {30'h0, irq_st_q};
          ATCS_IRQ_EN_OFS: s_axi_rdata <= {30'h0, irq_en_q};
          ATCS_IRQ_CL_OFS: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ATCS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  property p_one_state;
    @(posedge clk_i) disable iff (srst_i)
      state_q == ATCS_ST_IDLE || state_q == ATCS_ST_TRACK || state_q == ATCS_ST_CONV;
  endproperty
  a_one_state: assert property (p_one_state) else $error("Illegal sequencer state.");

  property p_pre_conv;
    @(posedge clk_i) disable iff (srst_i)
      start && state_q != ATCS_ST_CONV && mode == ATCS_MODE_PRE |=> state_q == ATCS_ST_CONV;
  endproperty
  a_pre_conv: assert property (p_pre_conv) else $error("Pre mode did not convert.");

  property p_post_track;
    @(posedge clk_i) disable iff (srst_i)
      start && state_q != ATCS_ST_CONV && mode == ATCS_MODE_POST |=> state_q == ATCS_ST_TRACK;
  endproperty
  a_post_track: assert property (p_post_track) else $error("Post mode did not track.");

  property p_track_to_conv;
    @(posedge clk_i) disable iff (srst_i)
      state_q == ATCS_ST_TRACK && sar_cnt_q == 4'hF && cnt_q == 9'h001 && cif.converter_subsystem_clock_tick
      && !start |=> state_q == ATCS_ST_CONV;
  endproperty
  a_track_to_conv: assert property (p_track_to_conv) else $error("Gap after tracking.");

  property p_post_idle;
    @(posedge clk_i) disable iff (srst_i)
      done_ev && mode == ATCS_MODE_POST |=> state_q == ATCS_ST_IDLE ##1 !sample_connect_o;
  endproperty
  a_post_idle: assert property (p_post_idle) else $error("Post mode kept tracking.");

  property p_dual_track;
    @(posedge clk_i) disable iff (srst_i)
      done_ev && mode == ATCS_MODE_DUAL |=> state_q == ATCS_ST_TRACK ##1 sample_connect_o;
  endproperty
  a_dual_track: assert property (p_dual_track) else $error("Dual mode did not track.");

  property p_done_flag;
    @(posedge clk_i) disable iff (srst_i)
      done_ev |=> irq_st_q[0];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("Done flag not set.");

  property p_sar_div;
    @(posedge clk_i) disable iff (srst_i)
      cif.sar_tick && !cif.burst_clock_select && cif.sar_clock_divider == 5'h01
      && state_q == ATCS_ST_CONV && sar_cnt_q < 4'hB |=> !cif.sar_tick ##1 cif.sar_tick;
  endproperty
  a_sar_div: assert property (p_sar_div) else $error("SAR divide ratio wrong.");

  property p_sys_clk;
    @(posedge clk_i) disable iff (srst_i)
      !cif.burst_clock_select |-> cif.converter_subsystem_clock_tick;
  endproperty
  a_sys_clk: assert property (p_sys_clk) else $error("System clock tick missing.");

  // A start refused during conversion must leave a trace that software can see.
  property p_ovr_flag;
    @(posedge clk_i) disable iff (srst_i)
      ovr_ev |=> irq_st_q[1];
  endproperty
  a_ovr_flag: assert property (p_ovr_flag) else $error("Overrun flag not set.");

  property p_irq_on;
    @(posedge clk_i) disable iff (srst_i)
      |(irq_st_q & irq_en_q) |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("Interrupt not raised.");

  property p_irq_off;
    @(posedge clk_i) disable iff (srst_i)
      !(|(irq_st_q & irq_en_q)) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("Stray interrupt.");

  property p_sar_count;
    @(posedge clk_i) disable iff (srst_i)
      done_ev |-> sar_cnt_q == 4'(ATCS_CONV_SAR - 1);
  endproperty
  a_sar_count: assert property (p_sar_count) else $error("Wrong SAR cycle count.");

  property p_dual_start;
    @(posedge clk_i) disable iff (srst_i)
      start && state_q != ATCS_ST_CONV && mode == ATCS_MODE_DUAL
      |=> state_q == ATCS_ST_TRACK && sar_cnt_q == 4'hF;
  endproperty
  a_dual_start: assert property (p_dual_start) else $error("Dual start not timed.");

  property p_idle_open;
    @(posedge clk_i) disable iff (srst_i)
      state_q == ATCS_ST_IDLE |=> !sample_connect_o;
  endproperty
  a_idle_open: assert property (p_idle_open) else $error("Input connected while idle.");

  property p_burst_clk;
    @(posedge clk_i) disable iff (srst_i)
      cif.burst_clock_select |-> cif.converter_subsystem_clock_tick == burst_tick_i;
  endproperty
  a_burst_clk: assert property (p_burst_clk) else $error("Burst tick not used.");
endmodule
`default_nettype wire

// ---- atcs_src_model.sv ----
// Convert-start trigger and burst oscillator model at the far side of the sequencer.
`timescale 1ns/10ps
`default_nettype none
module atcs_src_model #(
  parameter int BURST_DIV = 3
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic fire_i,
  output var  logic convert_start_o,
  output var  logic burst_tick_o
);
  logic [7:0] ph_q;
  // The oscillator runs free, so a start may land on any tick phase.
  always_ff @(posedge clk_i) begin
    if (srst_i || ph_q == 8'(BURST_DIV - 1)) begin
      ph_q <= 8'h00;
    end else begin
      ph_q <= ph_q + 8'h01;
    end
    burst_tick_o <= !srst_i && ph_q == 8'h00;
  end
  always_ff @(posedge clk_i) begin
    convert_start_o <= fire_i && !srst_i;
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the track and convert sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import atcs_pkg::*;
  logic        clk_i, srst_i, fire, convert_start_i, burst_tick_i;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, r;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        sample_connect_o, converting_o, sar_clk_tick_o, irq_o;
  int          bad_count, n_compared, cycles;
  int          seed = 32'hFBED0D09;
  logic [31:0] corner [5] = '{32'h0000_0000, 32'h0000_000D, 32'h0000_3806,
                              32'h0000_0803, 32'h0000_400D};
  atcs_seq dut (.clk_i, .srst_i, .convert_start_i, .burst_tick_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sample_connect_o, .converting_o, .sar_clk_tick_o, .irq_o);
  atcs_src_model #(.BURST_DIV(3)) src (.clk_i(clk_i), .srst_i(srst_i), .fire_i(fire),
    .convert_start_o(convert_start_i), .burst_tick_o(burst_tick_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // About 16 operations of under five hundred cycles each fit well below this ceiling.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int track_len(input logic [31:0] c);
    return (c[1:0] == ATCS_MODE_PRE) ? 0 : int'(c[3:2]) + ATCS_TRACK_EXTRA;
  endfunction
  function automatic int busy_len(input logic [31:0] c);
    return track_len(c) + ATCS_CONV_SAR * (int'(c[15:11]) + 1) + ATCS_CONV_EXTRA;
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c, input logic by_reg);
    int tn = 0;
    int cn = 0;
    int bn = 0;
    int sn = 0;
    axi_wr(ATCS_CFG_OFS, c, ATCS_RESP_OKAY);
    // The register start may launch before its write response, so count in parallel.
    fork
      if (by_reg) axi_wr(ATCS_CTRL_OFS, 32'h0000_0001, ATCS_RESP_OKAY);
      else pulse();
      begin
        do @(posedge clk_i); while (converting_o !== 1'b1);
        while (converting_o === 1'b1) begin
          cn += 1;
          tn += (sample_connect_o === 1'b1);
          bn += (burst_tick_i === 1'b1);
          sn += (sar_clk_tick_o === 1'b1);
          @(posedge clk_i);
        end
        sn += (sar_clk_tick_o === 1'b1);
      end
    join
    if (c[14]) begin
      check(32'(bn >= busy_len(c) - 1 && bn <= busy_len(c) + 1), 32'h1);
    end else begin
      check(32'(cn), 32'(busy_len(c)));
      check(32'(tn), 32'(track_len(c)));
    end
    check(32'(sn), 32'(ATCS_CONV_SAR));
    axi_rd(ATCS_IRQ_ST_OFS, rd, ATCS_RESP_OKAY);
    check(rd & 32'h1, 32'h1);
    check(32'(irq_o), 32'h1);
    axi_rd(ATCS_STAT_OFS, rd, ATCS_RESP_OKAY);
    check(rd & 32'h3, (c[1:0] == ATCS_MODE_DUAL) ? 32'h1 : 32'h0);
    axi_wr(ATCS_IRQ_CL_OFS, 32'h0000_0003, ATCS_RESP_OKAY);
    check(32'(sample_connect_o), 32'(c[1:0] == ATCS_MODE_DUAL));
  endtask
  initial begin
    srst_i        = 1'b1;
    fire          = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready  = 1'b1;
    s_axi_rready  = 1'b1;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    axi_rd(ATCS_CFG_OFS, rd, ATCS_RESP_OKAY);
    check(rd, ATCS_CFG_RST);
    axi_rd(ATCS_IRQ_ST_OFS, rd, ATCS_RESP_OKAY);
    check(rd, 32'h0);
    axi_wr(8'h40, 32'hFFFF_FFFF, ATCS_RESP_SLVERR);
    axi_rd(8'h40, rd, ATCS_RESP_SLVERR);
    axi_wr(ATCS_IRQ_EN_OFS, 32'h0, ATCS_RESP_OKAY);
    axi_wr(ATCS_CFG_OFS, 32'h0000_180D, ATCS_RESP_OKAY);
    pulse();
    do @(posedge clk_i); while (converting_o !== 1'b1);
    // Let the timed tracking end first, so the second start hits the conversion itself.
    repeat (8) @(posedge clk_i);
    pulse();
    axi_wr(ATCS_CFG_OFS, 32'h0000_0000, ATCS_RESP_OKAY);
    do @(posedge clk_i); while (converting_o !== 1'b0);
    axi_rd(ATCS_IRQ_ST_OFS, rd, ATCS_RESP_OKAY);
    check(rd, 32'h3);
    check(32'(irq_o), 32'h0);
    axi_rd(ATCS_CFG_OFS, rd, ATCS_RESP_OKAY);
    check(rd, 32'h0000_180D);
    axi_wr(ATCS_IRQ_EN_OFS, 32'h0000_0003, ATCS_RESP_OKAY);
    axi_rd(ATCS_IRQ_ST_OFS, rd, ATCS_RESP_OKAY);
    check(32'(irq_o), 32'h1);
    axi_wr(ATCS_IRQ_CL_OFS, 32'h0000_0003, ATCS_RESP_OKAY);
    axi_rd(ATCS_IRQ_ST_OFS, rd, ATCS_RESP_OKAY);
    check(rd, 32'h0);
    check(32'(irq_o), 32'h0);
    for (int i = 0; i < 5; i++) begin
      run(corner[i], i[0]);
    end
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      run(r & 32'h0000_380F, r[5]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
